/* File: attc_pkg.sv */
// shared constants for the autonomous threshold timer configuration block
package attc_pkg;
    localparam logic [7:0]  ADDR_TIMER_CFG  = 8'h27;
    localparam logic [7:0]  ADDR_UPPER_LO   = 8'h28;
    localparam logic [7:0]  ADDR_UPPER_HI   = 8'h29;
    localparam logic [7:0]  ADDR_LOWER_LO   = 8'h2a;
    localparam logic [7:0]  ADDR_LOWER_HI   = 8'h2b;
    localparam logic [7:0]  ADDR_UPPER_HYST = 8'h2c;
    localparam logic [7:0]  ADDR_LOWER_HYST = 8'h2d;
    localparam logic [7:0]  ADDR_ROUTE_CFG  = 8'h25;
    localparam logic [7:0]  RST_TIMER_CFG   = 8'h00;
    localparam logic [11:0] RST_LIMIT       = 12'h000;
    localparam logic [6:0]  RST_HYST        = 7'h00;
    localparam logic [1:0]  RST_ROUTE_ZERO  = 2'h1;
    localparam logic [1:0]  RST_ROUTE_ONE   = 2'h2;
    localparam int RATE_MSB   = 7;
    localparam int RATE_LSB   = 4;
    localparam int DELAY_MSB  = 3;
    localparam int DELAY_LSB  = 0;
    localparam int ROUTE0_LSB = 0;
    localparam int ROUTE1_LSB = 4;
    localparam int CLK_HZ     = 10_000_000;
    localparam int CNT_W      = 24;
    // sample period in ns for each rate code
    localparam int RATE_PERIOD_NS [16] = '{500, 1000, 3334, 10000, 30030, 100000,
        333334, 1000000, 2000000, 3003004, 4000000, 5000000, 6024097, 7142858,
        8000000, 9009010};
    // power-on delay in ns for each delay code
    localparam int DELAY_NS [16] = '{500, 1000, 3300, 10000, 30000, 100000, 330000,
        1000000, 2000000, 3000000, 4000000, 5000000, 6000000, 7000000, 8000000,
        9000000};
    localparam logic [1:0] ROUTE_NONE  = 2'h0;
    localparam logic [1:0] ROUTE_LOWER = 2'h1;
    localparam logic [1:0] ROUTE_UPPER = 2'h2;
    localparam logic [1:0] ROUTE_EITHER = 2'h3;
endpackage : attc_pkg

/* File: attc_window_cmp.sv */
// window comparator with hysteresis driving the two crossing flags
module attc_window_cmp (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sample_vld_i,
    input  wire logic [11:0] sample_i,
    input  wire logic        twos_comp_i,
    input  wire logic [11:0] upper_limit_i,
    input  wire logic [11:0] lower_limit_i,
    input  wire logic [6:0]  upper_hyst_i,
    input  wire logic [6:0]  lower_hyst_i,
    output logic             upper_flag_o,
    output logic             lower_flag_o
);
    typedef struct packed {
        logic upper;
        logic lower;
    } attc_cmp_s;

    attc_cmp_s st_r;
    attc_cmp_s st_nxt;

    // map to signed 14-bit so both codings compare alike
    function automatic logic signed [13:0] to_s(input logic [11:0] v, input logic tc);
        to_s = tc ? {{2{v[11]}}, v} : {2'b00, v} - 14'sd2048;
    endfunction

    logic signed [13:0] smp;
    logic signed [13:0] up_clr;
    logic signed [13:0] lo_clr;

    always_comb begin
        smp    = to_s(sample_i, twos_comp_i);
        up_clr = to_s(upper_limit_i, twos_comp_i) - $signed({7'b0, upper_hyst_i});
        lo_clr = to_s(lower_limit_i, twos_comp_i) + $signed({7'b0, lower_hyst_i});
        st_nxt = st_r;
        if (sample_vld_i) begin
            if (smp > to_s(upper_limit_i, twos_comp_i)) begin
                st_nxt.upper = 1'b1;
            end else if (smp < up_clr) begin
                st_nxt.upper = 1'b0;
            end
            if (smp < to_s(lower_limit_i, twos_comp_i)) begin
                st_nxt.lower = 1'b1;
            end else if (smp > lo_clr) begin
                st_nxt.lower = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign upper_flag_o = st_r.upper;
    assign lower_flag_o = st_r.lower;
endmodule // attc_window_cmp

/* File: attc_cfg.sv */
// threshold, hysteresis and sample timer configuration with flag routing

module attc_cfg (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        run_i,
    input  wire logic        companion_routed_i,
    input  wire logic        twos_comp_i,
    input  wire logic        result_vld_i,
    input  wire logic [11:0] result_i,
    output logic             companion_enable_output_o,
    output logic             sample_strobe_o,
    output logic             upper_crossing_flag_o,
    output logic             lower_crossing_flag_o,
    output logic             general_purpose_pin_zero_o,
    output logic             general_purpose_pin_one_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_POWER} attc_state_e;

    // all state of the block except the comparator flags, registered as one word
    typedef struct packed {
        logic [7:0]  timer_cfg;
        logic [11:0] upper_lim;
        logic [11:0] lower_lim;
        logic [6:0]  upper_hyst;
        logic [6:0]  lower_hyst;
        logic [1:0]  route0;
        logic [1:0]  route1;
        logic [7:0]  rdata;
        attc_state_e state;
        logic [23:0] cnt;
        logic        comp_en;
        logic        strobe;
        logic        pin0;
        logic        pin1;
    } attc_s;

    attc_s st_r;
    attc_s st_nxt;
    logic  upper_flag;
    logic  lower_flag;

    function automatic logic [23:0] period_cyc(input logic [3:0] code);
        period_cyc = 24'((attc_pkg::RATE_PERIOD_NS[code] * (attc_pkg::CLK_HZ / 1_000_000))
                     / 1000);
    endfunction

    function automatic logic [23:0] delay_cyc(input logic [3:0] code);
        delay_cyc = 24'((attc_pkg::DELAY_NS[code] * (attc_pkg::CLK_HZ / 1_000_000) + 999)
                    / 1000);
    endfunction

    // enable lead due once fewer cycles than the delay remain
    function automatic logic lead_due(input logic [23:0] left, input logic [3:0] code);
        lead_due = left < delay_cyc(code);
    endfunction

    function automatic logic route(input logic [1:0] sel, input logic up, input logic lo);
        unique case (sel)
            attc_pkg::ROUTE_NONE:  route = 1'b0;
            attc_pkg::ROUTE_LOWER: route = lo;
            attc_pkg::ROUTE_UPPER: route = up;
            attc_pkg::ROUTE_EITHER: route = up | lo;
        endcase
    endfunction

    // crossing flags come straight from the comparator registers
    attc_window_cmp u_cmp (
        .mclk_i        (mclk_i),
        .rst_n_i       (rst_n_i),
        .sample_vld_i  (result_vld_i),
        .sample_i      (result_i),
        .twos_comp_i   (twos_comp_i),
        .upper_limit_i (st_r.upper_lim),
        .lower_limit_i (st_r.lower_lim),
        .upper_hyst_i  (st_r.upper_hyst),
        .lower_hyst_i  (st_r.lower_hyst),
        .upper_flag_o  (upper_flag),
        .lower_flag_o  (lower_flag)
    );

    // decoded fields of the timer register
    logic [3:0] rate_code;
    logic [3:0] delay_code;

    always_comb begin
        st_nxt     = st_r;
        rate_code  = st_r.timer_cfg[attc_pkg::RATE_MSB:attc_pkg::RATE_LSB];
        delay_code = st_r.timer_cfg[attc_pkg::DELAY_MSB:attc_pkg::DELAY_LSB];
        st_nxt.strobe = 1'b0;
        // byte writes, unmapped addresses ignored
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                attc_pkg::ADDR_TIMER_CFG:  st_nxt.timer_cfg = reg_wdata_i;
                attc_pkg::ADDR_UPPER_LO:   st_nxt.upper_lim[7:0] = reg_wdata_i;
                attc_pkg::ADDR_UPPER_HI:   st_nxt.upper_lim[11:8] = reg_wdata_i[3:0];
                attc_pkg::ADDR_LOWER_LO:   st_nxt.lower_lim[7:0] = reg_wdata_i;
                attc_pkg::ADDR_LOWER_HI:   st_nxt.lower_lim[11:8] = reg_wdata_i[3:0];
                attc_pkg::ADDR_UPPER_HYST: st_nxt.upper_hyst = reg_wdata_i[6:0];
                attc_pkg::ADDR_LOWER_HYST: st_nxt.lower_hyst = reg_wdata_i[6:0];
                attc_pkg::ADDR_ROUTE_CFG: begin
                    st_nxt.route0 = reg_wdata_i[attc_pkg::ROUTE0_LSB +: 2];
                    st_nxt.route1 = reg_wdata_i[attc_pkg::ROUTE1_LSB +: 2];
                end
                default: ;
            endcase
        end
        // read data stands one cycle, zero otherwise
        st_nxt.rdata = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                attc_pkg::ADDR_TIMER_CFG:  st_nxt.rdata = st_r.timer_cfg;
                attc_pkg::ADDR_UPPER_LO:   st_nxt.rdata = st_r.upper_lim[7:0];
                attc_pkg::ADDR_UPPER_HI:   st_nxt.rdata = {4'h0, st_r.upper_lim[11:8]};
                attc_pkg::ADDR_LOWER_LO:   st_nxt.rdata = st_r.lower_lim[7:0];
                attc_pkg::ADDR_LOWER_HI:   st_nxt.rdata = {4'h0, st_r.lower_lim[11:8]};
                attc_pkg::ADDR_UPPER_HYST: st_nxt.rdata = {1'b0, st_r.upper_hyst};
                attc_pkg::ADDR_LOWER_HYST: st_nxt.rdata = {1'b0, st_r.lower_hyst};
                attc_pkg::ADDR_ROUTE_CFG:  st_nxt.rdata = {2'h0, st_r.route1, 2'h0, st_r.route0};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        unique case (st_r.state)
            ST_IDLE: begin
                st_nxt.comp_en = 1'b0;
                // a fresh run starts a full period before the first sample
                if (run_i) begin
                    st_nxt.state = ST_WAIT;
                    st_nxt.cnt   = period_cyc(rate_code) - 24'd1;
                end
            end
            // cnt holds the cycles left before the next sampling instant
            ST_WAIT: begin
                st_nxt.comp_en = 1'b0;
                if (!run_i) begin
                    st_nxt.state = ST_IDLE;
                end else if (st_r.cnt == 24'd0) begin
                    st_nxt.strobe = 1'b1;
                    st_nxt.cnt    = period_cyc(rate_code) - 24'd1;
                end else if (companion_routed_i && lead_due(st_r.cnt, delay_code)) begin
                    st_nxt.comp_en = 1'b1;
                    st_nxt.state   = ST_POWER;
                    st_nxt.cnt     = st_r.cnt - 24'd1;
                end else begin
                    st_nxt.cnt = st_r.cnt - 24'd1;
                end
            end
            // enable stands through the strobe cycle; a delay past the period keeps it up
            ST_POWER: begin
                if (!run_i) begin
                    st_nxt.state   = ST_IDLE;
                    st_nxt.comp_en = 1'b0;
                end else if (st_r.cnt == 24'd0) begin
                    st_nxt.strobe = 1'b1;
                    st_nxt.state  = ST_WAIT;
                    st_nxt.cnt    = period_cyc(rate_code) - 24'd1;
                end else begin
                    st_nxt.cnt = st_r.cnt - 24'd1;
                end
            end
            default: begin
                st_nxt.state   = ST_IDLE;
                st_nxt.comp_en = 1'b0;
            end
        endcase
        st_nxt.pin0 = route(st_r.route0, upper_flag, lower_flag);
        st_nxt.pin1 = route(st_r.route1, upper_flag, lower_flag);
    end

    // asynchronous reset loads the register defaults
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r            <= '0;
            st_r.timer_cfg  <= attc_pkg::RST_TIMER_CFG;
            st_r.upper_lim  <= attc_pkg::RST_LIMIT;
            st_r.lower_lim  <= attc_pkg::RST_LIMIT;
            st_r.upper_hyst <= attc_pkg::RST_HYST;
            st_r.lower_hyst <= attc_pkg::RST_HYST;
            st_r.route0     <= attc_pkg::RST_ROUTE_ZERO;
            st_r.route1     <= attc_pkg::RST_ROUTE_ONE;
            st_r.state      <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // every output is a register bit
    assign reg_rdata_o                = st_r.rdata;
    assign companion_enable_output_o  = st_r.comp_en;
    assign sample_strobe_o            = st_r.strobe;
    assign upper_crossing_flag_o      = upper_flag;
    assign lower_crossing_flag_o      = lower_flag;
    assign general_purpose_pin_zero_o = st_r.pin0;
    assign general_purpose_pin_one_o  = st_r.pin1;
endmodule // attc_cfg

/* File: attc_cfg_sva.sv */
// concurrent checks on the configuration block ports
module attc_cfg_sva (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        run_i,
    input wire logic        result_vld_i,
    input wire logic        companion_enable_output_o,
    input wire logic        sample_strobe_o,
    input wire logic        upper_crossing_flag_o,
    input wire logic        lower_crossing_flag_o,
    input wire logic        general_purpose_pin_zero_o,
    input wire logic        general_purpose_pin_one_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    AST_TIMER_RB: assert property (reg_wr_i && reg_addr_i == attc_pkg::ADDR_TIMER_CFG ##1
        reg_rd_i && reg_addr_i == attc_pkg::ADDR_TIMER_CFG |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("timer config read back differs from write");
    AST_LIMIT_RSV: assert property (reg_rd_i && reg_addr_i inside {8'h29, 8'h2b}
        |=> reg_rdata_o[7:4] == 4'h0) else $error("limit high byte reserved bits set");
    AST_HYST_RSV: assert property (reg_rd_i && reg_addr_i inside {8'h2c, 8'h2d}
        |=> !reg_rdata_o[7]) else $error("hysteresis reserved bit set");
    AST_STROBE_PULSE: assert property (sample_strobe_o |=> !sample_strobe_o)
        else $error("sample strobe wider than one cycle");
    AST_STROBE_RUN: assert property (sample_strobe_o |-> $past(run_i))
        else $error("sample strobe while timer stopped");
    AST_NO_RUN: assert property (!run_i [*3] |-> !sample_strobe_o && !companion_enable_output_o)
        else $error("timer outputs active while stopped");
    AST_UPPER_CAUSE: assert property ($changed(upper_crossing_flag_o) |-> $past(result_vld_i))
        else $error("upper flag moved without a result");
    AST_LOWER_CAUSE: assert property ($changed(lower_crossing_flag_o) |-> $past(result_vld_i))
        else $error("lower flag moved without a result");
    AST_PIN_SRC: assert property (general_purpose_pin_zero_o || general_purpose_pin_one_o
        |-> $past(upper_crossing_flag_o || lower_crossing_flag_o)) else $error("pin high without flag");
endmodule // attc_cfg_sva

bind attc_cfg attc_cfg_sva i_attc_cfg_sva (.*);

/* File: attc_host_model.sv */
// host side of the register port: byte writes and reads
module attc_host_model #(
    parameter bit SLOW_VARIANT = 1'b0
) (
    input  wire logic       mclk_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // strobes stay high across back to back calls; idle drops them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        // no fast rates on slow part
        if (SLOW_VARIANT && a == attc_pkg::ADDR_TIMER_CFG && d[7:4] < 4'h2) d[7:4] = 4'h2;
        @(posedge mclk_i);
        reg_wr_o <= 1'b1;
        reg_rd_o <= 1'b0;
        reg_addr_o <= a;
        reg_wdata_o <= d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b1;
        reg_addr_o <= a;
        reg_wdata_o <= ~reg_wdata_o;
    endtask
    task automatic idle();
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
    endtask
endmodule // attc_host_model

/* File: tb_attc_cfg.sv */
// self-checking bench for the configuration block
module tb_attc_cfg;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, run_i = 1'b0, routed = 1'b1, twos = 1'b1, vld = 1'b0;
    logic [11:0] res = 12'h000;
    logic       wr, rd, en, stb, uf, lf, p0, p1, rd_prev = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic [7:0] exp_q[$];
    logic [7:0] alist[9] = '{8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h25, 8'h30};
    logic [7:0] mlist[9] = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h7f, 8'h7f, 8'h33, 8'h00};
    int failures = 0, check_count = 0, n, m, seed;
    always #50 mclk_i = ~mclk_i;
    attc_host_model i_attc_host_model (.mclk_i(mclk_i), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata));
    attc_cfg i_attc_cfg (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .run_i(run_i),
        .companion_routed_i(routed), .twos_comp_i(twos), .result_vld_i(vld), .result_i(res),
        .companion_enable_output_o(en), .sample_strobe_o(stb), .upper_crossing_flag_o(uf),
        .lower_crossing_flag_o(lf), .general_purpose_pin_zero_o(p0),
        .general_purpose_pin_one_o(p1));
    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // read data is valid in the cycle after the strobe
    always @(negedge mclk_i) begin
        if (rd_prev && exp_q.size() > 0) chk("rdata", rdata, exp_q.pop_front());
        rd_prev = rd;
    end
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_attc_host_model.rd(a);
    endtask
    task automatic feed(input logic [11:0] v, input logic eu, input logic el);
        @(posedge mclk_i);
        vld <= 1'b1;
        res <= v;
        @(posedge mclk_i);
        vld <= 1'b0;
        @(negedge mclk_i);
        chk("upper flag", uf, eu);
        chk("lower flag", lf, el);
        @(negedge mclk_i);
        chk("pin zero", p0, el);
        chk("pin one", p1, eu);
    endtask
    task automatic next_strobe();
        n = 0;
        m = 0;
        do begin
            @(negedge mclk_i);
            n++;
            if (en === 1'b1) m++;
        end while (stb !== 1'b1 && n < 300);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk_i);
        failures++;
        end_sim();
    end
    initial begin
        seed = $urandom(32'h9edbd34a);
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        foreach (alist[i]) rdx(alist[i], alist[i] == 8'h25 ? 8'h21 : 8'h00);
        foreach (alist[i]) begin
            n = $urandom;
            i_attc_host_model.wr(alist[i], n[7:0]);
            rdx(alist[i], n[7:0] & mlist[i]);
        end
        i_attc_host_model.idle();
        $display("test registers done");
        i_attc_host_model.wr(8'h25, 8'h21);
        i_attc_host_model.wr(8'h28, 8'h64);
        i_attc_host_model.wr(8'h29, 8'h00);
        i_attc_host_model.wr(8'h2a, 8'h32);
        i_attc_host_model.wr(8'h2b, 8'h00);
        i_attc_host_model.wr(8'h2c, 8'h0a);
        i_attc_host_model.wr(8'h2d, 8'h05);
        i_attc_host_model.idle();
        feed(12'd101, 1'b1, 1'b0);
        feed(12'd95, 1'b1, 1'b0);
        feed(12'd89, 1'b0, 1'b0);
        feed(12'hffe, 1'b0, 1'b1);
        feed(12'd54, 1'b0, 1'b1);
        feed(12'd56, 1'b0, 1'b0);
        feed(12'd49, 1'b0, 1'b1);
        @(posedge mclk_i);
        twos <= 1'b0;
        feed(12'h800, 1'b1, 1'b0);
        @(posedge mclk_i);
        twos <= 1'b1;
        feed(12'd49, 1'b0, 1'b1);
        for (int c = 0; c < 4; c++) begin
            i_attc_host_model.wr(8'h25, {4'(3 - c), 4'(c)});
            rdx(8'h25, {4'(3 - c), 4'(c)});
            i_attc_host_model.idle();
            repeat (3) @(negedge mclk_i);
            chk("pin zero route", p0, c % 2);
            chk("pin one route", p1, (3 - c) % 2);
        end
        $display("test comparator done");
        for (int c = 0; c < 4; c++) begin
            i_attc_host_model.wr(8'h27, {4'(c), 4'(3 - c)});
            i_attc_host_model.idle();
            run_i <= 1'b1;
            next_strobe();
            chk("enable at strobe", en, 1'b1);
            next_strobe();
            chk("strobe period", n, c == 0 ? 5 : c == 1 ? 10 : c == 2 ? 33 : 100);
            chk("enable lead", m, c == 0 || c == 3 ? 5 : 10);
            @(posedge mclk_i);
            run_i <= 1'b0;
            repeat (4) @(negedge mclk_i);
            chk("enable stopped", en, 1'b0);
        end
        $display("test timer done");
        end_sim();
    end
endmodule // tb_attc_cfg
